//--- dfn_display_notify.sv
/*
 * display field notification: mode decode, completion flags, dma gating
 * and default-data substitution for a video display port, with an apb
 * register slave. assumes the timing generator, dma request source and
 * display fifo all run on pclk, so their signals need no synchroniser.
 */
// The implementer's own choices: the address map and the APB interface to the registers.
// Behaviour
// R01 - continuous mode displays fields without waiting for any acknowledge
// R02 - noncontinuous mode sets field or frame done flag per mode bits
// R03 - uncleared flag at next display: keep dma requests, raise not-acked
// R04 - fields not enabled for display issue no dma requests
// R05 - disabled fields keep timing but output default values in window
// R06 - field-1-only mode sets field1 done and complete flags
// R07 - field-1-only mode: not-acked if flag set at next field 1
// R08 - field-1-only mode shows progressive frame only with internal timing
// R09 - field-2-only mode sets field2 done, not-acked at next field 2
// R10 - both-field mode sets each field flag, checks each at next
// R11 - frame mode sets frame flag after field 2, checks next completion
// R12 - progressive frame mode sets frame flag after field 1
// R13 - external timing must be progressive in progressive frame mode
// R14 - software must reprogram dma and clear flags in time
// R15 - single frame mode: not-acked unless cleared before next field 1
// R16 - continuous single field modes set flags, never raise not-acked
// R17 - continuous frame mode sets frame flag after field 2, no not-acked
// R18 - continuous progressive mode uses frame flag, no not-acked
// R19 - reserved mode codes disable display of both fields
// R20 - flags stay set until cleared, sampled at next matching event
`timescale 1ns/1ps
`default_nettype none

module dfn_display_notify #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // field timing from the timing generator
  input wire logic field_start,
  input wire logic field_end,
  input wire logic field_id,
  input wire logic progressive,
  input wire logic in_window,
  input wire logic pix_strobe,
  input wire logic [DW-1:0] timing_data,
  // dma request source and display fifo
  input wire logic dma_req_raw,
  output logic dma_req,
  input wire logic [DW-1:0] fifo_data,
  output logic fifo_rd,
  // display output and notification flags
  output logic [DW-1:0] pix_out,
  output logic display_complete_irq_flag,
  output logic done_not_acked_irq
);

  // the default register sits at offset 8, so the address needs four bits
  if (AW < 4 || DW < 1 || DW > 32) begin : gen_bad_width
    $error("dfn_display_notify: unsupported AW or DW");
  end

  ////////////////////////////////////////////////////////////////////////
  // mode decode

  function automatic dfn_pkg::dfn_mode_s decode(
    input logic [dfn_pkg::CTL_W-1:0] c,
    input logic prog
  );
    dfn_pkg::dfn_mode_s m;
    logic [3:0] code;
    m = '0;
    code = {c[dfn_pkg::CTL_CONT], c[dfn_pkg::CTL_FRM],
            c[dfn_pkg::CTL_F2], c[dfn_pkg::CTL_F1]};
    m.cont = c[dfn_pkg::CTL_CONT];
    m.nak_on = ~c[dfn_pkg::CTL_CONT];
    unique case (code)
      4'h1: begin
        // a progressive frame only runs on internal timing codes
        m.show1 = ~prog | c[dfn_pkg::CTL_ITC]; // R08
        m.set1[dfn_pkg::FLG_F1] = 1'b1; // R06
      end
      4'h2: begin
        m.show2 = 1'b1;
        m.set2[dfn_pkg::FLG_F2] = 1'b1; // R09
      end
      4'h3: begin
        m.show1 = 1'b1;
        m.show2 = 1'b1;
        m.set1[dfn_pkg::FLG_F1] = 1'b1; // R10
        m.set2[dfn_pkg::FLG_F2] = 1'b1; // R10
      end
      4'h4, 4'hC: begin
        m.show1 = 1'b1;
        m.show2 = 1'b1;
        m.set2[dfn_pkg::FLG_FRM] = 1'b1; // R11 R17
      end
      4'h5, 4'hD: begin
        m.show1 = 1'b1;
        m.set1[dfn_pkg::FLG_FRM] = 1'b1; // R12 R18
      end
      4'h7: begin
        m.show1 = 1'b1;
        m.show2 = 1'b1;
        m.set2[dfn_pkg::FLG_FRM] = 1'b1; // R15
        m.frm_at_start = 1'b1; // R15
      end
      4'h9: begin
        m.show1 = 1'b1;
        m.set1[dfn_pkg::FLG_F1] = 1'b1; // R16
      end
      4'hA: begin
        m.show2 = 1'b1;
        m.set2[dfn_pkg::FLG_F2] = 1'b1; // R16
      end
      // reserved codes display nothing but timing still runs
      default: begin
        m.nak_on = 1'b0; // R19
      end
    endcase
    if (!c[dfn_pkg::CTL_EN]) begin
      m.show1 = 1'b0;
      m.show2 = 1'b0;
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [dfn_pkg::CTL_W-1:0] ctrl;
  logic [DW-1:0] dflt;
  logic wr_en;
  logic rd_setup;
  logic mapped;
  logic [dfn_pkg::FLG_N-1:0] flag_vec;
  logic [dfn_pkg::FLG_N-1:0] nak_vec;
  logic [dfn_pkg::FLG_N-1:0] set_vec;
  logic [dfn_pkg::FLG_N-1:0] chk_vec;
  logic [dfn_pkg::FLG_N-1:0] clr_vec;
  logic clr_dcmp;
  logic clr_nak;
  dfn_pkg::dfn_mode_s m_now;
  dfn_pkg::dfn_mode_s mode_q;
  dfn_pkg::dfn_field_e cur_fld;
  logic cur_show;

  assign mapped = paddr == AW'(dfn_pkg::OFF_CTRL) ||
                  paddr == AW'(dfn_pkg::OFF_STAT) ||
                  paddr == AW'(dfn_pkg::OFF_DFLT);
  assign wr_en = psel & penable & pwrite & mapped;
  assign rd_setup = psel & ~penable & ~pwrite;
  // read data is staged in the setup cycle, so every access takes one
  // access cycle and prdata still comes from a flop
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= dfn_pkg::CTRL_RST;
    end else if (wr_en && paddr == AW'(dfn_pkg::OFF_CTRL)) begin
      ctrl <= pwdata[dfn_pkg::CTL_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dflt <= dfn_pkg::DFLT_RST[DW-1:0];
    end else if (wr_en && paddr == AW'(dfn_pkg::OFF_DFLT)) begin
      dflt <= pwdata[DW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= 32'h0000_0000;
      if (paddr == AW'(dfn_pkg::OFF_CTRL)) begin
        prdata[dfn_pkg::CTL_W-1:0] <= ctrl;
      end else if (paddr == AW'(dfn_pkg::OFF_STAT)) begin
        prdata[dfn_pkg::FLG_N-1:0] <= flag_vec;
        prdata[dfn_pkg::STA_DCMP] <= display_complete_irq_flag;
        prdata[dfn_pkg::STA_NAK] <= done_not_acked_irq;
        prdata[dfn_pkg::STA_FLD] <= cur_fld == dfn_pkg::DFN_FIELD2;
        prdata[dfn_pkg::STA_SHOW] <= cur_show;
      end else if (paddr == AW'(dfn_pkg::OFF_DFLT)) begin
        prdata[DW-1:0] <= dflt;
      end
    end
  end

  // flag, complete and not-acked status bits clear by writing one
  assign clr_vec = (wr_en && paddr == AW'(dfn_pkg::OFF_STAT)) ?
                   pwdata[dfn_pkg::FLG_N-1:0] : '0;
  assign clr_dcmp = wr_en && paddr == AW'(dfn_pkg::OFF_STAT) &&
                    pwdata[dfn_pkg::STA_DCMP];
  assign clr_nak = wr_en && paddr == AW'(dfn_pkg::OFF_STAT) &&
                   pwdata[dfn_pkg::STA_NAK];

  ////////////////////////////////////////////////////////////////////////
  // field tracking

  assign m_now = decode(ctrl, progressive);

  // mode is frozen per field so a mid-field write cannot split a field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= '0;
      cur_fld <= dfn_pkg::DFN_FIELD1;
    end else if (field_start) begin
      mode_q <= m_now;
      cur_fld <= field_id ? dfn_pkg::DFN_FIELD2 : dfn_pkg::DFN_FIELD1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_show <= 1'b0;
    end else if (field_start) begin
      cur_show <= field_id ? m_now.show2 : m_now.show1; // R01
    end else if (field_end) begin
      cur_show <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // completion flags and not-acked checks

  logic end_f1;
  logic end_f2;
  logic start_f1;
  logic start_f2;

  assign end_f1 = field_end & cur_show & cur_fld == dfn_pkg::DFN_FIELD1;
  assign end_f2 = field_end & cur_show & cur_fld == dfn_pkg::DFN_FIELD2;
  assign start_f1 = field_start & ~field_id;
  assign start_f2 = field_start & field_id;

  // continuous modes only set flags; nak_on is low there
  assign set_vec = (end_f1 ? mode_q.set1 : '0) |
                   (end_f2 ? mode_q.set2 : '0); // R02

  assign chk_vec[dfn_pkg::FLG_F1] = start_f1 & m_now.nak_on &
                                    m_now.show1; // R07 R10
  assign chk_vec[dfn_pkg::FLG_F2] = start_f2 & m_now.nak_on &
                                    m_now.show2; // R09 R10
  // frame modes check at the next completion, single frame at next field 1
  assign chk_vec[dfn_pkg::FLG_FRM] =
      (mode_q.nak_on & ~mode_q.frm_at_start &
       set_vec[dfn_pkg::FLG_FRM]) | // R11 R12
      (start_f1 & m_now.nak_on & m_now.frm_at_start); // R15

  dfn_flag_if fi[dfn_pkg::FLG_N] ();

  genvar g;
  generate
    for (g = 0; g < dfn_pkg::FLG_N; g++) begin : gen_flag
      assign fi[g].set = set_vec[g];
      assign fi[g].clr = clr_vec[g];
      assign fi[g].check = chk_vec[g];
      assign flag_vec[g] = fi[g].flag;
      assign nak_vec[g] = fi[g].nak;
      dfn_flag_track u_trk (
        .pclk(pclk),
        .presetn(presetn),
        .f(fi[g].trk)
      );
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_complete_irq_flag <= 1'b0;
    end else if (|set_vec) begin
      display_complete_irq_flag <= 1'b1; // R06
    end else if (clr_dcmp) begin
      display_complete_irq_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_not_acked_irq <= 1'b0;
    end else if (|nak_vec) begin
      done_not_acked_irq <= 1'b1; // R03
    end else if (clr_nak) begin
      done_not_acked_irq <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // dma gating and output data

  // requests keep flowing even when a flag was left set
  assign dma_req = dma_req_raw & cur_show; // R03 R04
  assign fifo_rd = in_window & pix_strobe & cur_show;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_out <= '0;
    end else if (!in_window) begin
      pix_out <= timing_data;
    end else if (pix_strobe) begin
      pix_out <= cur_show ? fifo_data : dflt; // R05
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_dma_gated: assert property ( // R04
    dma_req |->
      (cur_fld == dfn_pkg::DFN_FIELD2 ? mode_q.show2 : mode_q.show1)
  ) else $error("dma request for a field not enabled");
  chk_dma_keeps: assert property ( // R03
    cur_show && dma_req_raw |-> dma_req
  ) else $error("dma request dropped in a displayed field");
  chk_default_data: assert property ( // R05
    in_window && pix_strobe && !cur_show |=> pix_out == $past(dflt)
  ) else $error("default value not driven for a disabled field");
  chk_f1_done: assert property ( // R06
    end_f1 && mode_q.set1[dfn_pkg::FLG_F1] |=>
      flag_vec[dfn_pkg::FLG_F1] && display_complete_irq_flag
  ) else $error("field 1 completion not flagged");
  chk_f2_done: assert property ( // R09
    end_f2 && mode_q.set2[dfn_pkg::FLG_F2] |=>
      flag_vec[dfn_pkg::FLG_F2] && display_complete_irq_flag
  ) else $error("field 2 completion not flagged");
  chk_frame_done: assert property ( // R11 R12
    (end_f2 && mode_q.set2[dfn_pkg::FLG_FRM]) ||
    (end_f1 && mode_q.set1[dfn_pkg::FLG_FRM]) |=>
      flag_vec[dfn_pkg::FLG_FRM] && display_complete_irq_flag
  ) else $error("frame completion not flagged");
  chk_nak_f1: assert property ( // R07
    start_f1 && m_now.nak_on && m_now.show1 &&
    flag_vec[dfn_pkg::FLG_F1] && !clr_vec[dfn_pkg::FLG_F1] |->
      ##2 done_not_acked_irq
  ) else $error("unacknowledged field 1 did not raise not-acked");
  chk_cont_quiet: assert property ( // R16
    ctrl[dfn_pkg::CTL_CONT] && mode_q.cont |=> !(|nak_vec)
  ) else $error("not-acked raised in continuous mode");
  chk_flag_hold: assert property ( // R20
    flag_vec[dfn_pkg::FLG_FRM] && !clr_vec[dfn_pkg::FLG_FRM] |=>
      flag_vec[dfn_pkg::FLG_FRM]
  ) else $error("frame flag dropped without a clear");

  cov_nak: cover property (|nak_vec ##1 done_not_acked_irq);
  cov_frame: cover property (end_f2 && mode_q.set2[dfn_pkg::FLG_FRM]);
  cov_dflt: cover property (in_window && pix_strobe && !cur_show);
  cov_cont: cover property (end_f1 && mode_q.cont);

endmodule

`default_nettype wire

//--- dfn_pkg.sv
/*
 * constants and types shared by the display field notification block.
 * assumes nothing of its surroundings; compiled before every other file.
 */
`default_nettype none

package dfn_pkg;

  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_DFLT = 8'h08;

  // control register bit positions
  localparam int CTL_EN = 0;
  localparam int CTL_F1 = 1;
  localparam int CTL_F2 = 2;
  localparam int CTL_FRM = 3;
  localparam int CTL_CONT = 4;
  localparam int CTL_ITC = 5;
  localparam int CTL_W = 6;

  // status register bit positions
  localparam int STA_F1_DONE = 0;
  localparam int STA_F2_DONE = 1;
  localparam int STA_FRM_DONE = 2;
  localparam int STA_DCMP = 3;
  localparam int STA_NAK = 4;
  localparam int STA_FLD = 8;
  localparam int STA_SHOW = 9;

  // completion flag indices, same order as the status bits
  localparam int FLG_F1 = 0;
  localparam int FLG_F2 = 1;
  localparam int FLG_FRM = 2;
  localparam int FLG_N = 3;

  // values after reset
  localparam logic [CTL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [31:0] DFLT_RST = 32'h0000_1080;

  typedef enum logic {DFN_FIELD1, DFN_FIELD2} dfn_field_e;

  // what the current mode bits ask of each field
  typedef struct packed {
    logic show1;
    logic show2;
    logic [FLG_N-1:0] set1;
    logic [FLG_N-1:0] set2;
    logic nak_on;
    logic frm_at_start;
    logic cont;
  } dfn_mode_s;

endpackage

`default_nettype wire

//--- dfn_flag_if.sv
/*
 * interface between the mode logic and one completion flag tracker.
 * assumes a single clock domain; no clocking block.
 */
`timescale 1ns/1ps
`default_nettype none

interface dfn_flag_if;
  logic set;
  logic clr;
  logic check;
  logic flag;
  logic nak;
  modport ctl (output set, output clr, output check, input flag, input nak);
  modport trk (input set, input clr, input check, output flag, output nak);
endinterface

`default_nettype wire

//--- dfn_flag_track.sv
/*
 * one sticky completion flag with its not-acknowledged check.
 * assumes set, clr and check are one-cycle pulses on pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module dfn_flag_track (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // flag events
  dfn_flag_if.trk f
);

  logic nak_q;

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f.flag <= 1'b0;
    end else if (f.set) begin
      f.flag <= 1'b1;
    end else if (f.clr) begin
      f.flag <= 1'b0;
    end
  end

  // the check looks at the old flag, before a same-cycle set lands;
  // a clear in that same cycle still counts as acknowledged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nak_q <= 1'b0;
    end else begin
      nak_q <= f.check & f.flag & ~f.clr; // R20
    end
  end

  assign f.nak = nak_q;

endmodule

`default_nettype wire

//--- dfn_video_src.sv
/*
 * far side model: field timing generator, fifo threshold source and fifo
 * data for the display notification block.
 * assumes one pclk domain; each field is launched by a one-cycle go pulse.
 */
`timescale 1ns/1ps
`default_nettype none

module dfn_video_src #(
  parameter int DW = 16
) (
  // control from the bench
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic fid,
  input wire logic prog,
  output logic busy,
  // timing and data towards the block
  output logic field_start,
  output logic field_end,
  output logic field_id,
  output logic progressive,
  output logic in_window,
  output logic pix_strobe,
  output logic [DW-1:0] timing_data,
  output logic dma_req_raw,
  output logic [DW-1:0] fifo_data
);
  logic [3:0] cnt;
  logic [7:0] tick;

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      field_id <= 1'b0;
      progressive <= 1'b0;
    end else if (go) begin
      cnt <= 4'h1;
      // progressive source never reports a second field
      field_id <= fid & ~prog;
      progressive <= prog;
    end else if (cnt != 4'h0) begin
      cnt <= (cnt == 4'hA) ? 4'h0 : cnt + 4'h1;
    end
  end

  // free-running so stale fifo words never look valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 8'h00;
    end else begin
      tick <= tick + 8'h01;
    end
  end

  assign busy = cnt != 4'h0;
  assign field_start = cnt == 4'h1;
  assign field_end = cnt == 4'h9;
  assign in_window = cnt >= 4'h3 && cnt <= 4'h6;
  assign pix_strobe = in_window;
  assign dma_req_raw = in_window;
  assign fifo_data = {8'hC0, tick};
  assign timing_data = {8'h80, ~tick};
endmodule

`default_nettype wire

//--- dfn_display_notify_tb.sv
/*
 * self-checking bench: apb register access plus a table of display modes,
 * each run over four fields without acknowledging the flags.
 * assumes the block answers apb in one access cycle and the video source
 * model drives all field timing.
 */
`timescale 1ns/1ps
`default_nettype none

module dfn_display_notify_tb;
  typedef struct packed {
    logic [7:0] ctl;
    logic prg;
    logic [3:0] disp;
    logic [3:0][7:0] st;
  } dfn_row_s;

  // slot 3 is the first field1, slot 0 the second field2
  localparam dfn_row_s ROWS [19] = '{
    '{8'h03, 1'b0, 4'b1010, 32'h0909_1919},
    '{8'h03, 1'b1, 4'b0000, 32'h0000_0000},
    '{8'h23, 1'b1, 4'b1111, 32'h0919_1919},
    '{8'h05, 1'b0, 4'b0101, 32'h000A_0A1A},
    '{8'h07, 1'b0, 4'b1111, 32'h090B_1B1B},
    '{8'h09, 1'b0, 4'b1111, 32'h000C_0C1C},
    '{8'h0B, 1'b1, 4'b1111, 32'h0C1C_1C1C},
    '{8'h0F, 1'b0, 4'b1111, 32'h000C_1C1C},
    '{8'h13, 1'b0, 4'b1010, 32'h0909_0909},
    '{8'h15, 1'b0, 4'b0101, 32'h000A_0A0A},
    '{8'h19, 1'b0, 4'b1111, 32'h000C_0C0C},
    '{8'h1B, 1'b1, 4'b1111, 32'h0C0C_0C0C},
    '{8'h01, 1'b0, 4'b0000, 32'h0},
    '{8'h0D, 1'b0, 4'b0000, 32'h0},
    '{8'h11, 1'b0, 4'b0000, 32'h0},
    '{8'h17, 1'b0, 4'b0000, 32'h0},
    '{8'h1D, 1'b0, 4'b0000, 32'h0},
    '{8'h1F, 1'b0, 4'b0000, 32'h0},
    '{8'h02, 1'b0, 4'b0000, 32'h0}
  };

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic go = 1'b0;
  logic fid = 1'b0;
  logic prog = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, busy, field_start, field_end, field_id;
  logic progressive, in_window, pix_strobe, dma_req_raw, dma_req, fifo_rd;
  logic dcmp, nak;
  logic [15:0] timing_data, fifo_data, pix_out;
  int err_count = 0;
  int compares = 0;

  always #20 pclk = ~pclk;

  dfn_display_notify #(.AW(8), .DW(16)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .field_start(field_start),
    .field_end(field_end), .field_id(field_id),
    .progressive(progressive), .in_window(in_window),
    .pix_strobe(pix_strobe), .timing_data(timing_data),
    .dma_req_raw(dma_req_raw), .dma_req(dma_req), .fifo_data(fifo_data),
    .fifo_rd(fifo_rd), .pix_out(pix_out),
    .display_complete_irq_flag(dcmp), .done_not_acked_irq(nak)
  );

  dfn_video_src #(.DW(16)) far (
    .pclk(pclk), .presetn(presetn), .go(go), .fid(fid), .prog(prog),
    .busy(busy), .field_start(field_start), .field_end(field_end),
    .field_id(field_id), .progressive(progressive),
    .in_window(in_window), .pix_strobe(pix_strobe),
    .timing_data(timing_data), .dma_req_raw(dma_req_raw),
    .fifo_data(fifo_data)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk32(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer; a read is compared under mask m
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic [31:0] e, input logic se);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      close_out();
    end
    chk32("pslverr", {31'h0, se}, {31'h0, pslverr});
    if (!w) begin
      chk32("prdata", e, prdata & m);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // runs one field; act tells whether dma or fifo reads were seen
  task automatic run_field(input logic id, input logic p, output logic act,
                           output logic [15:0] px);
    int n;
    act = 1'b0;
    px = 16'h0000;
    @(posedge pclk);
    go <= 1'b1;
    fid <= id;
    prog <= p;
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
      if (dma_req === 1'b1 || fifo_rd === 1'b1) begin
        act = 1'b1;
      end
      if (in_window === 1'b1) begin
        px = pix_out;
      end
    end while (busy === 1'b1 && n < 40);
    if (n >= 40) begin
      err_count++;
      close_out();
    end
    // not-acked lands two cycles after its check
    repeat (2) @(posedge pclk);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    logic act;
    logic [15:0] px;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b0, dfn_pkg::OFF_CTRL, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b0);
    acc(1'b0, dfn_pkg::OFF_STAT, 32'h0, 32'h0000_031F, 32'h0, 1'b0);
    acc(1'b0, dfn_pkg::OFF_DFLT, 32'h0, 32'hFFFF_FFFF,
        dfn_pkg::DFLT_RST, 1'b0);
    acc(1'b1, 8'h0C, 32'h0000_003F, 32'h0, 32'h0, 1'b1);
    acc(1'b0, 8'h0C, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b1);
    acc(1'b0, dfn_pkg::OFF_CTRL, 32'h0, 32'hFFFF_FFFF, 32'h0, 1'b0);
    acc(1'b1, dfn_pkg::OFF_DFLT, 32'h0000_5A3C, 32'h0, 32'h0, 1'b0);
    acc(1'b0, dfn_pkg::OFF_DFLT, 32'h0, 32'hFFFF_FFFF, 32'h5A3C, 1'b0);
    foreach (ROWS[i]) begin
      acc(1'b1, dfn_pkg::OFF_CTRL, {24'h0, ROWS[i].ctl}, 32'h0, 32'h0, 1'b0);
      acc(1'b1, dfn_pkg::OFF_STAT, 32'h0000_001F, 32'h0, 32'h0, 1'b0);
      for (int s = 3; s >= 0; s--) begin
        run_field(~s[0], ROWS[i].prg, act, px);
        chk32("dma_active", {31'h0, ROWS[i].disp[s]}, {31'h0, act});
        chk32("pix_hi", ROWS[i].disp[s] ? 32'hC0 : 32'h5A,
              {24'h0, px[15:8]});
        acc(1'b0, dfn_pkg::OFF_STAT, 32'h0, 32'h1F,
            {24'h0, ROWS[i].st[s]}, 1'b0);
        chk32("nak_pin", {31'h0, ROWS[i].st[s][4]}, {31'h0, nak});
        chk32("dcmp_pin", {31'h0, ROWS[i].st[s][3]}, {31'h0, dcmp});
      end
    end
    close_out();
  end
endmodule

`default_nettype wire
